// [logic/pls_pkg.sv]
package pls_pkg;
    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int IQ_W = 16;
    localparam int ACC_W = 48;
    localparam int GAIN_W = 16;
    localparam int CNT_W = 16;
    localparam int ITER_W = 8;
    localparam int SCHED_AW = 4;
    localparam int TRACE_AW = 6;
    localparam int DVD_W = ACC_W + 15;
    localparam logic [6:0] DIV_STEPS = 7'(DVD_W);
    localparam logic [2:0] POST_EXTRA = 3'h4;

    // ------------------------------------------------------------
    // gain values, q1.15
    // ------------------------------------------------------------
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h8000;
    localparam logic [GAIN_W-1:0] GAIN_AT_RESET = 16'h8000;
    localparam logic [16:0] RATIO_ONE = 17'h08000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic continuous;
        logic burst_enable;
        logic multi_servo;
        logic gain_step_limit_disable;
        logic reset_gain_on_fail;
        logic trigger_pass_mode;
        logic [CNT_W-1:0] burst_window_sample_count;
        logic [ITER_W-1:0] max_iterations;
        logic [ITER_W-1:0] min_iterations;
        logic [SCHED_AW-1:0] last_entry;
        logic [GAIN_W-1:0] initial_gain;
        logic [GAIN_W-1:0] default_gain;
        logic [GAIN_W-1:0] gain_limit;
        logic [GAIN_W-1:0] step_size;
    } pls_cfg_t;

    typedef struct packed {
        logic [CNT_W-1:0] num_samples;
        logic [ACC_W-1:0] desired;
        logic [ACC_W-1:0] limit_high;
        logic [ACC_W-1:0] limit_low;
    } pls_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_ACCUM = 3'h3,
        ST_CALC = 3'h2,
        ST_CHECK = 3'h6
    } pls_state_t;
endpackage

// [logic/pls_if.sv]
`timescale 1ns/1ps
interface pls_if;
    import pls_pkg::*;
    logic iq_valid;
    logic signed [IQ_W-1:0] i_sample;
    logic signed [IQ_W-1:0] q_sample;
    logic marker;
    pls_cfg_t cfg;
    logic cfg_load;
    logic leveling_start_bit;
    logic soft_reset;
    logic sched_write;
    logic [SCHED_AW-1:0] sched_addr;
    pls_entry_t sched_entry;
    logic [TRACE_AW-1:0] trace_addr;
    logic done;
    logic error;
    logic busy;
    logic [GAIN_W-1:0] gain;
    logic [ACC_W-1:0] trace_data;
    logic [TRACE_AW:0] trace_count;

    modport device (
        input iq_valid, i_sample, q_sample, marker, cfg, cfg_load, leveling_start_bit,
        input soft_reset, sched_write, sched_addr, sched_entry, trace_addr,
        output done, error, busy, gain, trace_data, trace_count
    );
    modport host (
        output iq_valid, i_sample, q_sample, marker, cfg, cfg_load, leveling_start_bit,
        output soft_reset, sched_write, sched_addr, sched_entry, trace_addr,
        input done, error, busy, gain, trace_data, trace_count
    );
endinterface

// [logic/pls_device.sv]
`timescale 1ns/1ps
// What this block does
// R1 - continuous mode nudges gain by step size
// R2 - in range needs power between limits
// R3 - gain change within limit unless disabled
// R4 - burst window passes counted samples after marker
// R5 - burst disabled passes every valid sample
// R6 - marker reloads counter, valid decrements it
// R7 - gated valid only while counter above zero
// R8 - valid and data share one edge
// R9 - one mode: trigger once on completion
// R10 - other mode: pass triggers only after completion
// R11 - accumulate raw squared magnitude, no scaling
// R12 - software writes thresholds in accumulator units
// R13 - start bit runs from first schedule entry
// R14 - separate done and error; success is done only
// R15 - reset stops loop, clears counters, done flag
// R16 - multi servo keeps burst config over reset
// R17 - single servo reset disables burst window
// R18 - calc_gain above unity: error; gain goes to unity, or default if reset_gain_on_fail
// R19 - software builds exponential averaging schedule
// R20 - raw gain always readable
// R21 - trace power per iteration, plus extra after
// R22 - in range and continuous: step, fetch again
// R23 - max iterations: error, idle; default gain only if reset_gain_on_fail
// R24 - step down above target, up below
module pls_device #(
    parameter int SCHED_DEPTH = 16,
    parameter int TRACE_DEPTH = 64
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_ref_trigger,
    output logic o_ref_trigger,
    output logic [pls_pkg::GAIN_W-1:0] o_digital_gain,
    pls_if.device bus
);
    import pls_pkg::*;

    if (SCHED_DEPTH < 1 || SCHED_DEPTH > 2**SCHED_AW || TRACE_DEPTH < 1
        || TRACE_DEPTH > 2**TRACE_AW)
    begin : g_bad_depth
        $error("pls_device: depth does not fit address width");
    end

    pls_state_t state;
    pls_entry_t sched_mem [SCHED_DEPTH];
    pls_entry_t entry;
    logic [ACC_W-1:0] trace_mem [TRACE_DEPTH];
    logic [SCHED_AW-1:0] sched_idx;
    logic [TRACE_AW:0] trace_wr;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] acc_left;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] mag2;
    logic signed [2*IQ_W-1:0] i_sq;
    logic signed [2*IQ_W-1:0] q_sq;
    logic burst_armed;
    logic gated_valid;
    logic [ITER_W-1:0] iter;
    logic [ITER_W-1:0] next_iter;
    logic [GAIN_W-1:0] gain;
    logic [6:0] div_cnt;
    logic [DVD_W-1:0] dvd;
    logic [ACC_W:0] rem;
    logic [ACC_W:0] rem_shift;
    logic [16:0] quo;
    logic quo_ovf;
    logic [15:0] ratio;
    logic [32:0] prod;
    logic [16:0] calc_gain;
    logic [16:0] step_up;
    logic [GAIN_W-1:0] step_gain;
    logic [GAIN_W-1:0] delta;
    logic in_power;
    logic in_range;
    logic cont_run;
    logic [2:0] post_left;
    logic done;
    logic error;
    logic done_q;

    // ------------------------------------------------------------
    // sample gating
    // ------------------------------------------------------------
    assign gated_valid = bus.iq_valid && (!burst_armed || win_cnt != '0); // R5 R7 R8

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            burst_armed <= 1'b0;
        else if (bus.cfg_load)
            burst_armed <= bus.cfg.burst_enable;
        else if (bus.soft_reset && !bus.cfg.multi_servo)
            burst_armed <= 1'b0; // R17 R16
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            win_cnt <= '0;
        else if (bus.soft_reset)
            win_cnt <= '0; // R15
        else if (burst_armed && bus.marker)
            win_cnt <= bus.cfg.burst_window_sample_count; // R4 R6
        else if (burst_armed && gated_valid)
            win_cnt <= win_cnt - CNT_W'(1); // R6
    end

    // ------------------------------------------------------------
    // datapath terms
    // ------------------------------------------------------------
    // raw |a|^2, the dBm scaling lives entirely in the written limits
    assign i_sq = bus.i_sample * bus.i_sample;
    assign q_sq = bus.q_sample * bus.q_sample;
    assign mag2 = ACC_W'($unsigned(i_sq)) + ACC_W'($unsigned(q_sq)); // R11 R12
    assign next_iter = iter + ITER_W'(1);
    assign rem_shift = {rem[ACC_W-1:0], dvd[DVD_W-1]};
    assign ratio = (quo_ovf || quo[16]) ? 16'hFFFF : quo[15:0];
    // first-order sqrt: g*(1+r)/2 saves a root unit, converges over iterations
    assign prod = 33'(gain) * 33'(RATIO_ONE + {1'b0, ratio});
    assign calc_gain = prod[32:16];
    assign step_up = {1'b0, gain} + {1'b0, bus.cfg.step_size};
    // the step limit judges the change this iteration would make, so the first pass counts too
    assign delta = (calc_gain >= {1'b0, gain}) ? GAIN_W'(calc_gain - {1'b0, gain})
        : gain - calc_gain[GAIN_W-1:0];
    assign in_power = acc >= entry.limit_low && acc <= entry.limit_high; // R2
    assign in_range = in_power && iter >= bus.cfg.min_iterations
        && (bus.cfg.gain_step_limit_disable || delta <= bus.cfg.gain_limit); // R3
    assign cont_run = bus.cfg.continuous && done;

    always_comb
    begin
        if (acc > entry.desired)
            step_gain = (gain > bus.cfg.step_size) ? gain - bus.cfg.step_size : '0; // R24
        else if (step_up > {1'b0, GAIN_UNITY})
            step_gain = GAIN_UNITY;
        else
            step_gain = step_up[GAIN_W-1:0]; // R24
    end

    // ------------------------------------------------------------
    // schedule and trace memories
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (bus.sched_write)
            sched_mem[bus.sched_addr] <= bus.sched_entry;
        if (state == ST_CHECK && trace_wr < TRACE_DEPTH)
            trace_mem[trace_wr[TRACE_AW-1:0]] <= acc; // R21
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            bus.trace_data <= '0;
        else
            bus.trace_data <= trace_mem[bus.trace_addr];
    end

    // ------------------------------------------------------------
    // serial divider: desired / accumulated
    // ------------------------------------------------------------
    // slow on purpose, one gain per many samples so area wins
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            div_cnt <= '0;
            dvd <= '0;
            rem <= '0;
            quo <= '0;
            quo_ovf <= 1'b0;
        end
        else if (bus.soft_reset)
            div_cnt <= '0; // R15
        else if (state == ST_ACCUM)
        begin
            div_cnt <= DIV_STEPS;
            dvd <= {entry.desired, 15'h0000};
            rem <= '0;
            quo <= '0;
            quo_ovf <= 1'b0;
        end
        else if (state == ST_CALC && div_cnt != '0)
        begin
            div_cnt <= div_cnt - 7'h01;
            dvd <= {dvd[DVD_W-2:0], 1'b0};
            quo <= {quo[15:0], rem_shift >= {1'b0, acc}};
            quo_ovf <= quo_ovf | quo[16];
            if (rem_shift >= {1'b0, acc})
                rem <= rem_shift - {1'b0, acc};
            else
                rem <= rem_shift;
        end
    end

    // ------------------------------------------------------------
    // leveling sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_IDLE;
            entry <= '0;
            sched_idx <= '0;
            acc <= '0;
            acc_left <= '0;
            iter <= '0;
            gain <= GAIN_AT_RESET;
            post_left <= '0;
            trace_wr <= '0;
            done <= 1'b0;
            error <= 1'b0;
        end
        else if (bus.soft_reset)
        begin
            state <= ST_IDLE; // R15
            sched_idx <= '0;
            trace_wr <= '0;
            acc_left <= '0;
            iter <= '0;
            post_left <= '0;
            done <= 1'b0;
            error <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (bus.leveling_start_bit)
                    begin
                        state <= ST_FETCH; // R13
                        sched_idx <= '0;
                        iter <= '0;
                        gain <= bus.cfg.initial_gain;
                        trace_wr <= '0;
                        done <= 1'b0;
                        error <= 1'b0;
                    end
                ST_FETCH:
                begin
                    entry <= sched_mem[sched_idx];
                    if (sched_idx != bus.cfg.last_entry)
                        sched_idx <= sched_idx + SCHED_AW'(1);
                    state <= ST_ACCUM;
                end
                ST_ACCUM:
                    if (acc_left == '0)
                    begin
                        acc <= '0;
                        acc_left <= entry.num_samples;
                        state <= (entry.num_samples == '0) ? ST_CALC : ST_ACCUM;
                        if (entry.num_samples == '0)
                            acc_left <= '0;
                    end
                    else if (gated_valid)
                    begin
                        acc <= acc + mag2; // R11
                        acc_left <= acc_left - CNT_W'(1);
                        if (acc_left == CNT_W'(1))
                            state <= ST_CALC;
                    end
                ST_CALC:
                    // continuous tracking skips the division altogether
                    if (cont_run || post_left != '0 || div_cnt == '0)
                        state <= ST_CHECK;
                ST_CHECK:
                begin
                    if (trace_wr < TRACE_DEPTH)
                        trace_wr <= trace_wr + (TRACE_AW+1)'(1); // R21
                    if (post_left != '0)
                    begin
                        post_left <= post_left - 3'h1; // R21
                        state <= (post_left == 3'h1) ? ST_IDLE : ST_FETCH;
                    end
                    else if (cont_run)
                    begin
                        gain <= step_gain; // R1
                        state <= ST_FETCH;
                    end
                    else if (in_range)
                    begin
                        done <= 1'b1; // R14
                        if (bus.cfg.continuous)
                        begin
                            gain <= step_gain; // R22
                            state <= ST_FETCH;
                        end
                        else
                        begin
                            post_left <= POST_EXTRA;
                            state <= ST_FETCH;
                        end
                    end
                    else if (calc_gain > {1'b0, GAIN_UNITY} || next_iter >= bus.cfg.max_iterations)
                    begin
                        error <= 1'b1; // R18 R23
                        if (bus.cfg.reset_gain_on_fail)
                            gain <= bus.cfg.default_gain; // R23
                        else if (calc_gain > {1'b0, GAIN_UNITY})
                            gain <= GAIN_UNITY; // R18
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        gain <= calc_gain[GAIN_W-1:0];
                        iter <= next_iter;
                        state <= ST_FETCH;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reference trigger routing
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_q <= 1'b0;
            o_ref_trigger <= 1'b0;
        end
        else
        begin
            done_q <= done;
            if (bus.cfg.trigger_pass_mode)
                o_ref_trigger <= done && i_ref_trigger; // R10
            else
                o_ref_trigger <= done && !done_q; // R9
        end
    end

    assign bus.done = done; // R14
    assign bus.error = error;
    assign bus.busy = state != ST_IDLE;
    assign bus.gain = gain; // R20
    assign bus.trace_count = trace_wr;
    assign o_digital_gain = gain;
endmodule

// [logic/pls_host.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host end: sample source and software command side
// ------------------------------------------------------------
// thresholds and schedule arrive precomputed in accumulator units
module pls_host (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_iq_valid,
    input wire logic signed [pls_pkg::IQ_W-1:0] i_i_sample,
    input wire logic signed [pls_pkg::IQ_W-1:0] i_q_sample,
    input wire logic i_marker,
    input wire pls_pkg::pls_cfg_t i_cfg,
    input wire logic i_cfg_load,
    input wire logic i_start,
    input wire logic i_soft_reset,
    input wire logic i_sched_write,
    input wire logic [pls_pkg::SCHED_AW-1:0] i_sched_addr,
    input wire pls_pkg::pls_entry_t i_sched_entry,
    input wire logic [pls_pkg::TRACE_AW-1:0] i_trace_addr,
    output logic o_done,
    output logic o_error,
    output logic o_success,
    output logic o_busy,
    output logic [pls_pkg::GAIN_W-1:0] o_gain,
    output logic [pls_pkg::ACC_W-1:0] o_trace_data,
    output logic [pls_pkg::TRACE_AW:0] o_trace_count,
    pls_if.host bus
);
    import pls_pkg::*;

    // ------------------------------------------------------------
    // drive side, one register stage
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bus.iq_valid <= 1'b0;
            bus.i_sample <= '0;
            bus.q_sample <= '0;
            bus.marker <= 1'b0;
        end
        else
        begin
            bus.iq_valid <= i_iq_valid; // R8
            bus.i_sample <= i_i_sample; // R8
            bus.q_sample <= i_q_sample;
            bus.marker <= i_marker;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bus.cfg <= '0;
            bus.cfg_load <= 1'b0;
            bus.leveling_start_bit <= 1'b0;
            bus.soft_reset <= 1'b0;
            bus.sched_write <= 1'b0;
            bus.sched_addr <= '0;
            bus.sched_entry <= '0;
            bus.trace_addr <= '0;
        end
        else
        begin
            bus.cfg <= i_cfg;
            bus.cfg_load <= i_cfg_load;
            bus.leveling_start_bit <= i_start; // R13
            bus.soft_reset <= i_soft_reset;
            bus.sched_write <= i_sched_write; // R19
            bus.sched_addr <= i_sched_addr;
            bus.sched_entry <= i_sched_entry; // R12
            bus.trace_addr <= i_trace_addr;
        end
    end

    // ------------------------------------------------------------
    // status side
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_done <= 1'b0;
            o_error <= 1'b0;
            o_success <= 1'b0;
            o_busy <= 1'b0;
            o_gain <= GAIN_AT_RESET;
            o_trace_data <= '0;
            o_trace_count <= '0;
        end
        else
        begin
            o_done <= bus.done;
            o_error <= bus.error;
            o_success <= bus.done && !bus.error; // R14
            o_busy <= bus.busy;
            o_gain <= bus.gain;
            o_trace_data <= bus.trace_data;
            o_trace_count <= bus.trace_count;
        end
    end
endmodule

// [testbench/pls_assertions.sv]
`timescale 1ns/1ps
module pls_assertions (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic leveling_start_bit,
    input wire logic soft_reset,
    input wire logic done,
    input wire logic error,
    input wire logic busy,
    input wire logic [pls_pkg::GAIN_W-1:0] gain,
    input wire logic [pls_pkg::TRACE_AW:0] trace_count
);
    import pls_pkg::*;
    // ----------
    // checks on the link between host and device
    // ----------
    default clocking ck @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    a_reset_clears_status: assert property (soft_reset |=> ##[0:1] !(busy || done || error))
        else $error("soft reset left status set");
    a_start_sets_busy: assert property (leveling_start_bit && !busy && !soft_reset |-> ##[1:2] busy)
        else $error("start did not make the servo busy");
    a_gain_ceiling: assert property (gain <= GAIN_UNITY)
        else $error("gain above unity");
    // once idle the gain must not drift; start reloads it, hence the past guard
    a_idle_gain_held: assert property (!busy && !$past(busy) && !$past(leveling_start_bit)
        |-> $stable(gain))
        else $error("gain moved while idle");
    a_trace_bounded: assert property (trace_count <= 7'h40)
        else $error("trace count beyond buffer");
    a_trace_one_step: assert property (trace_count <= $past(trace_count) + 7'h01)
        else $error("trace count jumped");
    a_done_from_busy: assert property ($rose(done) |-> $past(busy))
        else $error("done rose while idle");
    a_error_to_idle: assert property ($rose(error) |-> $past(busy) && !busy)
        else $error("error without return to idle");
    a_done_holds: assert property (done && !soft_reset && !leveling_start_bit
        && !$past(soft_reset) && !$past(leveling_start_bit) |=> done)
        else $error("done dropped on its own");
endmodule

// [testbench/pls_tb_top.sv]
`timescale 1ns/1ps
module pls_tb_top;
    import pls_pkg::*;
    localparam logic [ACC_W-1:0] ACC4 = 48'h80000;
    localparam logic signed [IQ_W-1:0] AMP = 16'sh0100;
    logic i_clock, i_reset_n, stream_on, cfg_load, start, sreset, marker, ref_in, swr;
    logic valid, done, error, success, busy, ref_out;
    logic signed [IQ_W-1:0] si, sq;
    logic [GAIN_W-1:0] gain, dgain, g0;
    logic [ACC_W-1:0] tdata;
    logic [TRACE_AW:0] tcount;
    logic [TRACE_AW-1:0] taddr;
    pls_cfg_t cfg;
    pls_entry_t ent;
    int err_total, comparisons, cycles, trigs, t0;

    pls_if u_pls_if ();
    pls_host u_pls_host (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_iq_valid(valid),
        .i_i_sample(si), .i_q_sample(sq), .i_marker(marker), .i_cfg(cfg),
        .i_cfg_load(cfg_load), .i_start(start), .i_soft_reset(sreset), .i_sched_write(swr),
        .i_sched_addr(4'h0), .i_sched_entry(ent), .i_trace_addr(taddr), .o_done(done),
        .o_error(error), .o_success(success), .o_busy(busy), .o_gain(gain),
        .o_trace_data(tdata), .o_trace_count(tcount), .bus(u_pls_if.host));
    pls_device u_pls_device (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ref_trigger(ref_in),
        .o_ref_trigger(ref_out), .o_digital_gain(dgain), .bus(u_pls_if.device));
    pls_assertions u_pls_assertions (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .leveling_start_bit(u_pls_if.leveling_start_bit), .soft_reset(u_pls_if.soft_reset),
        .done(u_pls_if.done), .error(u_pls_if.error), .busy(u_pls_if.busy),
        .gain(u_pls_if.gain), .trace_count(u_pls_if.trace_count));

    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // idle cycles carry junk samples so a leak into the sum shows up
    always @(posedge i_clock)
    begin
        valid <= stream_on & cycles[0];
        si <= (stream_on & cycles[0]) ? AMP : ~AMP;
        sq <= (stream_on & cycles[0]) ? AMP : ~AMP;
        ref_in <= (cycles[3:0] == 4'hF);
        trigs <= trigs + int'(ref_out === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [ACC_W-1:0] e, input logic [ACC_W-1:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pulse(input int which);
        @(posedge i_clock);
        start <= (which == 0);
        sreset <= (which == 1);
        cfg_load <= (which == 2);
        marker <= (which == 3);
        @(posedge i_clock);
        {start, sreset, cfg_load, marker} <= 4'h0;
    endtask

    task automatic entry(input logic [ACC_W-1:0] des, input logic [ACC_W-1:0] lo);
        @(posedge i_clock);
        swr <= 1'b1;
        ent <= '{16'h0004, des, lo + 48'h200, lo};
        @(posedge i_clock);
        swr <= 1'b0;
    endtask

    task automatic run(input int lim);
        pulse(1);
        pulse(0);
        repeat (4) @(posedge i_clock);
        while (done !== 1'b1 && error !== 1'b1 && lim > 0)
        begin
            @(posedge i_clock);
            lim--;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        {i_reset_n, stream_on, cfg_load, start, sreset, marker, swr} = 7'h00;
        taddr = 6'h00;
        ent = '0;
        cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0002, 8'h08, 8'h00, 4'h0,
            16'h4000, 16'h1234, 16'h0100, 16'h0010};
        repeat (8) @(posedge i_clock);
        chk_word("reset gain", ACC_W'(GAIN_AT_RESET), ACC_W'(dgain));
        i_reset_n <= 1'b1;
        stream_on <= 1'b1;
        // twice the target power: a big gain change is only accepted with the limit off
        for (int d = 0; d < 2; d++)
        begin
            cfg.gain_step_limit_disable <= d[0];
            entry(ACC4 >> 1, ACC4 - 48'h100);
            pulse(2);
            t0 = trigs;
            run(2000);
            chk_bit("done", d[0], done);
            chk_bit("error", !d[0], error);
            chk_bit("success", d[0], success);
            chk_word("gain", d[0] ? 48'h4000 : 48'h1234, ACC_W'(dgain));
            repeat (400) @(posedge i_clock);
            taddr <= 6'(tcount - 7'h01);
            repeat (4) @(posedge i_clock);
            chk_word("trace", ACC4, tdata);
            chk_word("trigs", ACC_W'(d), ACC_W'(trigs - t0));
        end
        $display("test gain limit over");
        cfg.reset_gain_on_fail <= 1'b0;
        cfg.initial_gain <= GAIN_UNITY;
        entry(ACC4 << 1, ACC4 + 48'h100);
        run(2000);
        chk_bit("error", 1'b1, error);
        chk_word("gain", ACC_W'(GAIN_UNITY), ACC_W'(dgain));
        $display("test saturation over");
        cfg.initial_gain <= 16'h4000;
        cfg.burst_enable <= 1'b1;
        cfg.multi_servo <= 1'b1;
        cfg.trigger_pass_mode <= 1'b1;
        entry(ACC4, ACC4 - 48'h100);
        pulse(2);
        t0 = trigs;
        run(300);
        chk_bit("busy", 1'b1, busy);
        chk_word("trigs", 48'h0, ACC_W'(trigs - t0));
        pulse(3);
        repeat (40) @(posedge i_clock);
        chk_bit("done", 1'b0, done);
        pulse(3);
        repeat (200) @(posedge i_clock);
        chk_bit("done", 1'b1, done);
        t0 = trigs;
        repeat (160) @(posedge i_clock);
        chk_word("trigs", 48'hA, ACC_W'(trigs - t0));
        cfg.multi_servo <= 1'b0;
        run(2000);
        chk_bit("done", 1'b1, done);
        $display("test burst window over");
        cfg.continuous <= 1'b1;
        cfg.trigger_pass_mode <= 1'b0;
        for (int d = 0; d < 2; d++)
        begin
            entry(ACC4 + 48'h1 - 48'(2 * d), ACC4 - 48'h100);
            run(2000);
            chk_bit("done", 1'b1, done);
            repeat (300) @(posedge i_clock);
            chk_bit("busy", 1'b1, busy);
            chk_bit("dir", 1'b1, d ? gain < 16'h3FF0 : gain > 16'h4000);
            if (d == 0)
                chk_word("step", 48'h0, ACC_W'(gain[3:0]));
            pulse(1);
            repeat (4) @(posedge i_clock);
            g0 = dgain;
            repeat (200) @(posedge i_clock);
            chk_bit("busy", 1'b0, busy);
            chk_word("held", ACC_W'(g0), ACC_W'(dgain));
        end
        $display("test continuous over");
        end_of_test();
    end
endmodule
